/* rtl/epp17_consts.vh */
// constants of the enhanced parallel port cycle engine
// assumes: included by bare name from the rtl files
`ifndef EPP17_CONSTS_VH
`define EPP17_CONSTS_VH

// host port offsets
`define OFF_DATA 11'h000
`define OFF_STATUS 11'h001
`define OFF_CONTROL 11'h002
`define OFF_EPP_ADDR 11'h003
`define OFF_EPP_DATA0 11'h004
`define OFF_EPP_DATA3 11'h007
`define OFF_ECP_FIFO 11'h400
`define OFF_CONFIG_B 11'h401
`define OFF_EXT_CTRL 11'h402

// extended control mode field codes
`define MODE_SPP 3'h0
`define MODE_BIDIR 3'h1
`define MODE_COMPAT_FIFO 3'h2
`define MODE_ECP 3'h3
`define MODE_EPP 3'h4
`define MODE_TEST 3'h6
`define MODE_CONFIG 3'h7

// device control bit positions
`define DCR_STROBE 0
`define DCR_AUTOFD 1
`define DCR_INIT 2
`define DCR_SELIN 3
`define DCR_ACKINT 4
`define DCR_DIR 5
// device status timeout bit
`define DSR_TIMEOUT 0

// reset values and the config a read value
`define DCR_RST 6'h00
`define ECR_RST 6'h00
`define DATA_RST 8'h00
`define CONFIG_A_VAL 8'h10

// watchdog: 10 us at 40 MHz
`define WDOG_NS 10000
`define CLK_MHZ 40
`define WDOG_CYC ((`WDOG_NS * `CLK_MHZ + 999) / 1000)

// shared fifo shape
`define PWORD_W 8
`define FIFO_DEPTH 16

`endif

/* rtl/epp17_parallel_cycle_engine.v */
// enhanced parallel port cycle engine with standard port registers
// assumes: host pulses one read or write and waits for host_done_o
//
// What this block does
// - idle strobes and reset follow the standard control port
// - watchdog times each enhanced cycle from its strobe phase
// - watchdog expiry aborts cycle, sets status bit0
// - wait low stretches host cycle until high
// - clearing direction asserts write select before write
// - write drives byte, then asserts matching strobe
// - write ends: sync, strobe released, byte kept
// - direction 1 with strobe bit 0 releases write select, floats bus
// - read: strobe, peripheral data, wait high, end
// - write select, strobes, reset driven active low
// - peripheral interrupt passes through, not inverted
// - only data and address strobes overridden during a cycle
// - all fifo registers share one 16-byte fifo
// - data, status, control readable in every mode; data writes in ecp mode go to the fifo
// - config b shows chosen interrupt and dma
// - fifo port word is 8 bits
// - offset 3 runs an address strobe cycle
// - offsets 4 to 7 run data strobe cycles
`include "epp17_consts.vh"
`default_nettype none

module epp17_parallel_cycle_engine (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [10:0] host_addr_i,
  input wire host_wr_i,
  input wire host_rd_i,
  input wire [7:0] host_wdata_i,
  output reg [7:0] host_rdata_o,
  output reg host_done_o,
  input wire [2:0] cfg_irq_sel_i,
  input wire [2:0] cfg_dma_sel_i,
  input wire [7:0] port_data_bus_i,
  output reg [7:0] port_data_bus_o,
  output reg port_data_bus_oe_n_o,
  output reg write_select_n_o,
  output reg data_strobe_n_o,
  output reg addr_strobe_n_o,
  output reg periph_reset_n_o,
  input wire periph_wait_n_i,
  input wire periph_interrupt_i,
  input wire ack_n_i,
  input wire busy_i,
  input wire paper_end_i,
  input wire select_i,
  input wire fault_n_i,
  output reg irq_o
);

localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_STROBE = 2'h2;
localparam ST_END = 2'h3;
// watchdog terminal count, cut to the counter width on purpose
localparam [31:0] WDOG_LAST_W = `WDOG_CYC - 1;
localparam [8:0] WDOG_LAST = WDOG_LAST_W[8:0];

////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [14:0] pin_meta_q;
reg [14:0] pin_sync_q;
wire [7:0] pd_s;
wire wait_n_s;
wire ack_n_s;
wire busy_s;
wire paper_end_s;
wire select_s;
wire fault_n_s;
wire periph_interrupt_s;

// two flops on every input coming from the cable
always @(posedge sys_clk_i)
begin
  if (srst_i)
  begin
    pin_meta_q <= 15'h0000;
    pin_sync_q <= 15'h0000;
  end
  else
  begin
    pin_meta_q <= {periph_interrupt_i, fault_n_i, select_i,
      paper_end_i, busy_i, ack_n_i, periph_wait_n_i,
      port_data_bus_i};
    pin_sync_q <= pin_meta_q;
  end
end

assign pd_s = pin_sync_q[7:0];
assign wait_n_s = pin_sync_q[8];
assign ack_n_s = pin_sync_q[9];
assign busy_s = pin_sync_q[10];
assign paper_end_s = pin_sync_q[11];
assign select_s = pin_sync_q[12];
assign fault_n_s = pin_sync_q[13];
assign periph_interrupt_s = pin_sync_q[14];

////////////////////////////////////////////////////////////////////////
// registers and cycle state
reg [5:0] dcr_q;
reg [5:0] ecr_q;
reg [7:0] pd_out_q;
reg timeout_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg cyc_addr_q;
reg cyc_read_q;
reg [8:0] wdog_q;
wire [2:0] mode;
wire epp_mode;
wire fifo_mode;
wire epp_sel;
wire epp_req;
wire cyc_ok;
wire cyc_tmo;
wire [7:0] dsr;
wire [7:0] cfg_b;
wire [7:0] ecr_rd;
wire fifo_in_ready;
wire fifo_out_valid;
wire [7:0] fifo_out_data;
wire fifo_full;
wire fifo_empty;
wire fifo_push;
wire fifo_pop;
wire strobe_ph;
wire wr_mode;

assign mode = ecr_q[5:3];
assign epp_mode = (mode == `MODE_EPP);
assign fifo_mode = (mode == `MODE_COMPAT_FIFO) |
  (mode == `MODE_ECP) | (mode == `MODE_TEST);

// address 3 or 4..7 in enhanced mode starts a strobe cycle
assign epp_sel = epp_mode & (host_addr_i >= `OFF_EPP_ADDR) &
  (host_addr_i <= `OFF_EPP_DATA3);
assign epp_req = (host_wr_i | host_rd_i) & epp_sel &
  (state_q == ST_IDLE);

// cycle ends on wait high or watchdog expiry
assign cyc_ok = (state_q == ST_STROBE) & wait_n_s;
assign cyc_tmo = (state_q == ST_STROBE) & ~wait_n_s &
  (wdog_q == WDOG_LAST);

assign dsr = {~busy_s, ack_n_s, paper_end_s, select_s, fault_n_s,
  2'b00, timeout_q};
assign cfg_b = {1'b0, irq_o, cfg_irq_sel_i,
  cfg_dma_sel_i};
assign ecr_rd = {ecr_q, fifo_full, fifo_empty};

////////////////////////////////////////////////////////////////////////
// shared fifo behind every fifo register
assign fifo_push = host_wr_i & (state_q == ST_IDLE) & fifo_in_ready &
  (((host_addr_i == `OFF_ECP_FIFO) & fifo_mode) |
  ((host_addr_i == `OFF_DATA) & (mode == `MODE_ECP)));
assign fifo_pop = host_rd_i & (state_q == ST_IDLE) &
  (host_addr_i == `OFF_ECP_FIFO) & fifo_mode;

// one common store, 8-bit port word
port_fifo #(
  .WIDTH(`PWORD_W),
  .DEPTH(`FIFO_DEPTH)
) u_fifo (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .in_valid_i(fifo_push),
  .in_ready_o(fifo_in_ready),
  .in_data_i(host_wdata_i),
  .out_valid_o(fifo_out_valid),
  .out_ready_i(fifo_pop),
  .out_data_o(fifo_out_data),
  .full_o(fifo_full),
  .empty_o(fifo_empty)
);

////////////////////////////////////////////////////////////////////////
// enhanced cycle sequencer next state
always @*
begin
  state_d = state_q;
  case (state_q)
    ST_IDLE:
    begin
      if (epp_req)
        state_d = ST_SETUP;
    end
    ST_SETUP:
      state_d = ST_STROBE;
    ST_STROBE:
    begin
      if (cyc_ok | cyc_tmo)
        state_d = ST_END;
    end
    ST_END:
      state_d = ST_IDLE;
    default:
      state_d = ST_IDLE;
  endcase
end

// strobe phase decided from the coming state
assign strobe_ph = (state_d == ST_STROBE);
// strobe bit forces write mode during enhanced operation
assign wr_mode = ~dcr_q[`DCR_DIR] | dcr_q[`DCR_STROBE];

// state, watchdog and cycle attributes
always @(posedge sys_clk_i)
begin
  if (srst_i)
  begin
    state_q <= ST_IDLE;
    cyc_addr_q <= 1'b0;
    cyc_read_q <= 1'b0;
    wdog_q <= 9'h000;
  end
  else
  begin
    state_q <= state_d;
    if (epp_req)
    begin
      cyc_addr_q <= (host_addr_i == `OFF_EPP_ADDR);
      cyc_read_q <= host_rd_i;
      wdog_q <= 9'h000;
    end
    else if (state_q == ST_STROBE && ~cyc_ok && ~cyc_tmo)
      wdog_q <= wdog_q + 9'h001;
  end
end

////////////////////////////////////////////////////////////////////////
// software registers
always @(posedge sys_clk_i)
begin
  if (srst_i)
  begin
    dcr_q <= `DCR_RST;
    ecr_q <= `ECR_RST;
    pd_out_q <= `DATA_RST;
    timeout_q <= 1'b0;
  end
  else
  begin
    if (host_wr_i && state_q == ST_IDLE)
    begin
      if (host_addr_i == `OFF_DATA && mode != `MODE_ECP)
        pd_out_q <= host_wdata_i;
      if (host_addr_i == `OFF_CONTROL)
        dcr_q <= host_wdata_i[5:0];
      if (host_addr_i == `OFF_EXT_CTRL)
        ecr_q <= host_wdata_i[7:2];
      if (epp_req)
        pd_out_q <= host_wdata_i;
    end
    // set wins over a clear in the same cycle
    if (cyc_tmo)
      timeout_q <= 1'b1;
    else if (host_wr_i && state_q == ST_IDLE &&
      host_addr_i == `OFF_STATUS && host_wdata_i[`DSR_TIMEOUT])
      timeout_q <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// host answer: done pulse and read data
always @(posedge sys_clk_i)
begin
  if (srst_i)
  begin
    host_done_o <= 1'b0;
    host_rdata_o <= 8'h00;
  end
  else
  begin
    host_done_o <= 1'b0;
    if (cyc_ok | cyc_tmo)
    begin
      // wait states end here
      host_done_o <= 1'b1;
      host_rdata_o <= cyc_read_q ? pd_s : 8'h00;
    end
    else if ((host_wr_i | host_rd_i) && state_q == ST_IDLE &&
      ~epp_sel)
    begin
      host_done_o <= 1'b1;
      host_rdata_o <= 8'h00;
      if (host_rd_i)
      begin
        case (host_addr_i)
          `OFF_DATA:
          begin
            if (mode == `MODE_SPP || ~dcr_q[`DCR_DIR])
              host_rdata_o <= pd_out_q;
            else
              host_rdata_o <= pd_s;
          end
          `OFF_STATUS:
            host_rdata_o <= dsr;
          `OFF_CONTROL:
            host_rdata_o <= {2'b00, dcr_q};
          `OFF_ECP_FIFO:
          begin
            if (mode == `MODE_CONFIG)
              host_rdata_o <= `CONFIG_A_VAL;
            else if (fifo_out_valid & fifo_mode)
              host_rdata_o <= fifo_out_data;
          end
          `OFF_CONFIG_B:
          begin
            if (mode == `MODE_CONFIG)
              host_rdata_o <= cfg_b;
          end
          `OFF_EXT_CTRL:
            host_rdata_o <= ecr_rd;
          default:
            host_rdata_o <= 8'h00;
        endcase
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// port pins, all registered
always @(posedge sys_clk_i)
begin
  if (srst_i)
  begin
    port_data_bus_o <= `DATA_RST;
    port_data_bus_oe_n_o <= 1'b0;
    write_select_n_o <= 1'b1;
    data_strobe_n_o <= 1'b1;
    addr_strobe_n_o <= 1'b1;
    periph_reset_n_o <= 1'b0;
    irq_o <= 1'b0;
  end
  else
  begin
    // written byte stays latched after the cycle
    port_data_bus_o <= (epp_req & host_wr_i) ? host_wdata_i :
      pd_out_q;
    irq_o <= periph_interrupt_s & dcr_q[`DCR_ACKINT];
    periph_reset_n_o <= dcr_q[`DCR_INIT];
    if (epp_mode)
    begin
      // direction and strobe bits together steer select and drivers
      write_select_n_o <= ~wr_mode;
      port_data_bus_oe_n_o <= ~wr_mode;
      if (state_d == ST_IDLE)
      begin
        data_strobe_n_o <= ~dcr_q[`DCR_AUTOFD];
        addr_strobe_n_o <= ~dcr_q[`DCR_SELIN];
      end
      else
      begin
        // released in setup and end, asserted in strobe
        data_strobe_n_o <= ~(strobe_ph & ~cyc_addr_q &
          ~epp_req);
        addr_strobe_n_o <= ~(strobe_ph & cyc_addr_q &
          ~epp_req);
      end
    end
    else
    begin
      // standard, bidirectional, fifo and configuration operation
      write_select_n_o <= ~dcr_q[`DCR_STROBE];
      data_strobe_n_o <= ~dcr_q[`DCR_AUTOFD];
      addr_strobe_n_o <= ~dcr_q[`DCR_SELIN];
      port_data_bus_oe_n_o <= (mode != `MODE_SPP) &
        dcr_q[`DCR_DIR];
    end
  end
end

endmodule

`default_nettype wire

/* rtl/port_fifo.v */
// synchronous fifo with valid and ready on both sides
// assumes: one clock, synchronous active-high reset
`default_nettype none

module port_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o,
  output wire full_o,
  output wire empty_o
);

localparam AW = $clog2(DEPTH);

reg [WIDTH-1:0] mem_q [0:DEPTH-1];
reg [AW-1:0] wr_ptr_q;
reg [AW-1:0] rd_ptr_q;
reg [AW:0] count_q;
reg settled_q;
wire push;
wire pop;

////////////////////////////////////////////////////////////////////////
// flags and handshakes
assign full_o = (count_q == DEPTH[AW:0]);
assign empty_o = (count_q == {(AW+1){1'b0}});
assign in_ready_o = ~full_o;
assign out_valid_o = ~empty_o & settled_q; // output word settled
assign push = in_valid_i & in_ready_o;
assign pop = out_valid_o & out_ready_i;

////////////////////////////////////////////////////////////////////////
// storage, registered read port
always @(posedge sys_clk_i)
begin
  if (push)
    mem_q[wr_ptr_q] <= in_data_i;
  out_data_o <= mem_q[rd_ptr_q];
end

// pointers and fill count
always @(posedge sys_clk_i)
begin
  if (srst_i)
  begin
    wr_ptr_q <= {AW{1'b0}};
    rd_ptr_q <= {AW{1'b0}};
    count_q <= {(AW+1){1'b0}};
    settled_q <= 1'b0;
  end
  else
  begin
    settled_q <= ~(push | pop);
    if (push)
      wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
    if (pop)
      rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
    if (push & ~pop)
      count_q <= count_q + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      count_q <= count_q - {{AW{1'b0}}, 1'b1};
  end
end

endmodule

`default_nettype wire

/* verif/epp17_engine_asserts.sv */
// port assertions for the parallel cycle engine
// assumes: bound to the engine top, one clock, sync reset
`default_nettype none
module epp17_engine_asserts (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic host_done_o,
  input wire logic [7:0] port_data_bus_o,
  input wire logic port_data_bus_oe_n_o,
  input wire logic write_select_n_o,
  input wire logic data_strobe_n_o,
  input wire logic addr_strobe_n_o,
  input wire logic periph_wait_n_i,
  input wire logic periph_interrupt_i,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] stall_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // cycles of data strobe held against a low wait
  always_ff @(posedge sys_clk_i)
    if (srst_i || host_wr_i || host_rd_i || periph_wait_n_i)
      stall_q <= 10'h000;
    else if (!data_strobe_n_o)
      stall_q <= stall_q + 10'h001;
  ////////////////////////////////////////////////////////////
  chk_done_single: assert property (host_done_o |=> !host_done_o)
    else $error("done longer than one cycle");
  chk_wait_stall: assert property (host_done_o |->
    stall_q < 10'd3 || stall_q > 10'd395)
    else $error("done while wait low");
  chk_wdog_limit: assert property (stall_q < 10'd410)
    else $error("cycle never aborted");
  chk_abort_release: assert property (
    host_done_o && stall_q > 10'd395 |-> data_strobe_n_o)
    else $error("strobe held after abort");
  chk_bus_hold: assert property ((!data_strobe_n_o ||
    !addr_strobe_n_o) && !port_data_bus_oe_n_o |=> $stable(port_data_bus_o))
    else $error("bus moved under strobe");
  chk_wsel_drive: assert property (
    !write_select_n_o |-> !port_data_bus_oe_n_o)
    else $error("write select without drive");
  chk_read_float: assert property ((!data_strobe_n_o ||
    !addr_strobe_n_o) && write_select_n_o |-> port_data_bus_oe_n_o)
    else $error("bus driven during read");
  chk_irq_pass: assert property (
    $rose(irq_o) |-> $past(periph_interrupt_i, 3))
    else $error("irq without input");
endmodule
bind epp17_parallel_cycle_engine epp17_engine_asserts chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i), .host_done_o(host_done_o),
  .port_data_bus_o(port_data_bus_o),
  .port_data_bus_oe_n_o(port_data_bus_oe_n_o),
  .write_select_n_o(write_select_n_o), .data_strobe_n_o(data_strobe_n_o),
  .addr_strobe_n_o(addr_strobe_n_o), .periph_wait_n_i(periph_wait_n_i),
  .periph_interrupt_i(periph_interrupt_i), .irq_o(irq_o));
`default_nettype wire

/* verif/epp17_parallel_cycle_engine_test.sv */
// bench for the parallel cycle engine with a peripheral model
// assumes: engine and model share the 40 MHz clock
`default_nettype none
module epp17_parallel_cycle_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stall = 1'b0;
  logic periph_interrupt = 1'b0, done, oe_n, wsel_n, ds_n, as_n, prst_n, wait_n, irq;
  logic [10:0] addr = 11'h000;
  logic [7:0] wdata = 8'h00, rbyte = 8'h00, rdata, pd_o, pd_i, ldat, ladr;
  logic [7:0] got;
  logic [4:0] stat = 5'h00;
  logic [9:0] dly = 10'h002;
  int mismatches = 0, samples_checked = 0, cyc = 0, took;
  always #12.5 clk = ~clk;
  epp17_parallel_cycle_engine dut (
    .sys_clk_i(clk), .srst_i(rst), .host_addr_i(addr), .host_wr_i(wr),
    .host_rd_i(rd), .host_wdata_i(wdata), .host_rdata_o(rdata),
    .host_done_o(done), .cfg_irq_sel_i(3'h5), .cfg_dma_sel_i(3'h3),
    .port_data_bus_i(pd_i), .port_data_bus_o(pd_o),
    .port_data_bus_oe_n_o(oe_n), .write_select_n_o(wsel_n),
    .data_strobe_n_o(ds_n), .addr_strobe_n_o(as_n),
    .periph_reset_n_o(prst_n), .periph_wait_n_i(wait_n),
    .periph_interrupt_i(periph_interrupt), .ack_n_i(stat[3]), .busy_i(stat[4]),
    .paper_end_i(stat[2]), .select_i(stat[1]), .fault_n_i(stat[0]),
    .irq_o(irq));
  epp_periph_model peer (
    .clk_i(clk), .data_strobe_n_i(ds_n), .addr_strobe_n_i(as_n),
    .periph_reset_n_i(prst_n), .dev_data_i(pd_o), .dev_oe_n_i(oe_n),
    .delay_i(dly), .stall_i(stall), .read_byte_i(rbyte),
    .wait_n_o(wait_n), .bus_o(pd_i), .last_data_o(ldat),
    .last_addr_o(ladr));
  ////////////////////////////////////////////////////////////
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    if (g !== e)
      mismatches++;
  endtask
  // one host access, bounded wait for done, then the gap
  task automatic acc(input logic [10:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge clk);
    #2;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge clk);
    #2;
    wr = 1'b0;
    rd = 1'b0;
    took = 1;
    while (done !== 1'b1 && took < 500)
    begin
      @(posedge clk);
      #2;
      took++;
    end
    cmp8({7'h00, done}, 8'h01);
    got = rdata;
    repeat (2) @(posedge clk);
    #2;
  endtask
  task automatic t_regs;
    stat = 5'h0A;
    repeat (4) @(posedge clk);
    acc(11'h001, 1'b0, 8'h00);
    cmp8(got, {~stat[4], stat[3:0], 3'b000});
    acc(11'h402, 1'b1, 8'hE0);
    acc(11'h400, 1'b0, 8'h00);
    cmp8(got, 8'h10);
    acc(11'h401, 1'b0, 8'h00);
    cmp8({2'b00, got[5:0]}, 8'h2B);
    acc(11'h010, 1'b0, 8'h00);
    cmp8(got, 8'h00);
    acc(11'h002, 1'b1, 8'h0B);
    cmp8({4'h0, wsel_n, ds_n, as_n, prst_n}, 8'h00);
    acc(11'h002, 1'b1, 8'h04);
    cmp8({4'h0, wsel_n, ds_n, as_n, prst_n}, 8'h0F);
  endtask
  task automatic t_epp;
    acc(11'h402, 1'b1, 8'h80);
    acc(11'h002, 1'b1, 8'h04);
    cmp8({6'h00, wsel_n, oe_n}, 8'h00);
    for (int i = 4; i < 8; i++)
    begin
      dly = 10'(i * 3);
      acc(11'(i), 1'b1, 8'hA0 + 8'(i));
      cmp8({7'h00, took > int'(dly)}, 8'h01);
      cmp8(ldat, 8'hA0 + 8'(i));
      cmp8(pd_o, 8'hA0 + 8'(i));
    end
    acc(11'h003, 1'b1, 8'h3C);
    cmp8(ladr, 8'h3C);
    acc(11'h002, 1'b1, 8'h24);
    cmp8({6'h00, wsel_n, oe_n}, 8'h03);
    acc(11'h002, 1'b1, 8'h25);
    cmp8({6'h00, wsel_n, oe_n}, 8'h00);
    acc(11'h002, 1'b1, 8'h24);
    rbyte = 8'h5A;
    acc(11'h006, 1'b0, 8'h00);
    cmp8(got, 8'h5A);
    dly = 10'h000;
    rbyte = 8'hC3;
    acc(11'h003, 1'b0, 8'h00);
    cmp8(got, 8'hC3);
  endtask
  task automatic t_abort;
    acc(11'h002, 1'b1, 8'h04);
    stall = 1'b1;
    acc(11'h005, 1'b1, 8'h77);
    stall = 1'b0;
    cmp8({7'h00, took > 397 && took < 405}, 8'h01);
    cmp8({6'h00, ds_n, as_n}, 8'h03);
    acc(11'h001, 1'b0, 8'h00);
    cmp8({7'h00, got[0]}, 8'h01);
    acc(11'h001, 1'b1, 8'h01);
    acc(11'h001, 1'b0, 8'h00);
    cmp8({7'h00, got[0]}, 8'h00);
    periph_interrupt = 1'b1;
    acc(11'h002, 1'b1, 8'h14);
    cmp8({7'h00, irq}, 8'h01);
    periph_interrupt = 1'b0;
    repeat (5) @(posedge clk);
    cmp8({7'h00, irq}, 8'h00);
  endtask
  // shared fifo in ecp mode, then a bidirectional read
  task automatic t_fifo;
    rbyte = 8'h96;
    acc(11'h402, 1'b1, 8'h60);
    acc(11'h400, 1'b1, 8'h11);
    acc(11'h000, 1'b1, 8'h22);
    acc(11'h402, 1'b0, 8'h00);
    cmp8(got, 8'h60);
    acc(11'h400, 1'b0, 8'h00);
    cmp8(got, 8'h11);
    acc(11'h400, 1'b0, 8'h00);
    cmp8(got, 8'h22);
    acc(11'h402, 1'b0, 8'h00);
    cmp8(got, 8'h61);
    acc(11'h402, 1'b1, 8'h20);
    acc(11'h002, 1'b1, 8'h20);
    cmp8({6'h00, oe_n, prst_n}, 8'h02);
    cmp8(ladr, 8'h00);
    acc(11'h000, 1'b0, 8'h00);
    cmp8(got, ~rbyte);
  endtask
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence after reset
  initial
  begin
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    @(posedge clk);
    #2;
    cmp8({4'h0, wsel_n, ds_n, as_n, prst_n}, 8'h0E);
    t_regs;
    t_epp;
    t_abort;
    t_fifo;
    close_out;
  end
  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out;
    end
  end
endmodule
`default_nettype wire

/* verif/epp_periph_model.sv */
// peripheral on the enhanced port: wait, read data, capture
// assumes: engine clock, pins resolved here for the engine
`default_nettype none
module epp_periph_model (
  input wire logic clk_i,
  input wire logic data_strobe_n_i,
  input wire logic addr_strobe_n_i,
  input wire logic periph_reset_n_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_n_i,
  input wire logic [9:0] delay_i,
  input wire logic stall_i,
  input wire logic [7:0] read_byte_i,
  output var logic wait_n_o,
  output var logic [7:0] bus_o,
  output var logic [7:0] last_data_o,
  output var logic [7:0] last_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt;
  logic ds_q, as_q;
  logic drv = 1'b0;
  initial wait_n_o = 1'b0;
  // wait low when ready, high once the strobe has lasted long enough
  always @(posedge clk_i)
  begin
    ds_q <= data_strobe_n_i;
    as_q <= addr_strobe_n_i;
    if (!periph_reset_n_i)
    begin
      last_data_o <= 8'h00;
      last_addr_o <= 8'h00;
    end
    if (data_strobe_n_i && addr_strobe_n_i)
    begin
      cnt <= 10'h000;
      wait_n_o <= 1'b0;
      drv <= 1'b0;
      if (!ds_q && !dev_oe_n_i) last_data_o <= dev_data_i;
      if (!as_q && !dev_oe_n_i) last_addr_o <= dev_data_i;
    end
    else
    begin
      cnt <= cnt + 10'h001;
      drv <= dev_oe_n_i;
      if (cnt > delay_i && !stall_i) wait_n_o <= 1'b1;
    end
  end
  // data pins: engine, peripheral, or a released bus
  always @*
    if (!dev_oe_n_i) bus_o = dev_data_i;
    else if (drv) bus_o = read_byte_i;
    else bus_o = ~read_byte_i;
endmodule
`default_nettype wire
